// ### core/phy_irq_consts.vh
/*
  Register indices, field positions and reset values of the PHY status and
  interrupt block. The APB byte address of a register is four times its index.
*/
`ifndef PHY_IRQ_CONSTS_VH
`define PHY_IRQ_CONSTS_VH

`define IDX_PHY_RESOLVED_STATUS    10'h010
`define IDX_INTERRUPT_CONTROL      10'h011
`define IDX_INTERRUPT_EVENT_STATUS 10'h012

`define STS_LINK_BIT               0
`define STS_SPEED10_BIT            1
`define STS_DUPLEX_BIT             2
`define STS_RESET                  3'h0

`define CTL_INT_OE_BIT             0
`define CTL_GLOBAL_EN_BIT          1
`define CTL_TEST_INT_BIT           2
`define CTL_RESET                  3'h0

`define EVT_COUNT                  7
`define EVT_STATUS_LSB             8
`define EVT_ENABLE_LSB             0
`define EVT_STATUS_RESET           7'h00
`define EVT_ENABLE_RESET           7'h00

`define EVT_RX_ERR_HALF            0
`define EVT_FALSE_CARRIER_HALF     1
`define EVT_AN_COMPLETE            2
`define EVT_DUPLEX_CHANGE          3
`define EVT_SPEED_CHANGE           4
`define EVT_LINK_CHANGE            5
`define EVT_ENERGY_CHANGE          6

`endif

// ### core/event_edge_detect.v
/*
  Turns a vector of levels into one-cycle event pulses, per bit either on any
  change or on a rising edge only. Levels are synchronous to clk.
*/
`timescale 1ns/1ps
module event_edge_detect #(
  parameter            W         = 1,
  parameter [W-1:0]    RISE_ONLY = {W{1'b0}}
) (
  input  wire          clk,
  input  wire          rst_n,
  input  wire [W-1:0]  level,
  output wire [W-1:0]  pulse
);
  reg  [W-1:0] prev_reg;
  reg          primed_reg;

  // The first cycle after reset only loads the history, so no false event fires
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg   <= {W{1'b0}};
      primed_reg <= 1'b0;
    end else begin
      prev_reg   <= level;
      primed_reg <= 1'b1;
    end
  end

  assign pulse = {W{primed_reg}} & (level ^ prev_reg) & (~RISE_ONLY | level);
endmodule

// ### core/sticky_flags.v
/*
  Bank of sticky flags. A set in the same cycle as a clear keeps the flag set.
*/
`timescale 1ns/1ps
module sticky_flags #(
  parameter            W = 1
) (
  input  wire          clk,
  input  wire          rst_n,
  input  wire [W-1:0]  set,
  input  wire [W-1:0]  clr,
  output reg  [W-1:0]  flags
);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags <= {W{1'b0}};
    end else begin
      flags <= (flags & ~clr) | set;
    end
  end
endmodule

// ### core/phy_status_interrupt_ctrl.v
/*
  PHY resolved status and interrupt control with an APB register slave.
  Holds the resolved status, interrupt control and event status/enable
  registers, detects events and drives the shared power-down/interrupt pin.
  Assumes all status inputs are synchronous to pclk and a zero-wait APB master.
*/
// Local design decision: the APB slave port.
// Overview of operation
// RULE_01: Status bit 2 reports resolved duplex
// RULE_02: Speed/duplex only updated with qualified link
// RULE_03: Status bit 1 reports 10 Mb/s speed
// RULE_04: Status bit 0 mirrors link, never read-cleared
// RULE_05: Control bits 15:3 ignore writes, read zero
// RULE_06: Test interrupt bit holds interrupt asserted
// RULE_07: Control bit 1 gates event interrupts globally
// RULE_08: Control bit 0 selects shared pin role
// RULE_09: Seven event sources feed the interrupt
// RULE_10: Each source has its own enable
// RULE_11: Event status sticks until status read; the code also clears a bit on a write of one
// RULE_12: Status sets regardless of any enable
// RULE_13: Interrupt needs per-event and global enable
// RULE_14: Reading event status clears pending bits
// RULE_15: Interrupt output is a level signal
`timescale 1ns/1ps
`include "phy_irq_consts.vh"
module phy_status_interrupt_ctrl #(
  parameter            ADDR_W = 12
) (
  input  wire              pclk,
  input  wire              presetn,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output wire              pready,
  output wire              pslverr,
  input  wire              link_up,
  input  wire              an_enable,
  input  wire              an_complete,
  input  wire              speed_is_10,
  input  wire              full_duplex,
  input  wire              energy_detect,
  input  wire              false_carrier_half_full,
  input  wire              rx_error_half_full,
  input  wire              powerdown_irq_shared_pin_in,
  output wire              powerdown_irq_shared_pin_out,
  output wire              powerdown_irq_shared_pin_oe,
  output wire              power_down_req,
  output wire              irq
);

  localparam EW = `EVT_COUNT;

  // Which event sources fire on a rising edge only; the rest on any change
  localparam [EW-1:0] RISE_MASK = (7'h01 << `EVT_RX_ERR_HALF)
                                | (7'h01 << `EVT_FALSE_CARRIER_HALF)
                                | (7'h01 << `EVT_AN_COMPLETE);

  reg  [2:0]        status_reg;
  reg  [2:0]        status_next;
  reg  [2:0]        control_reg;
  reg  [2:0]        control_next;
  reg  [EW-1:0]     enable_reg;
  reg  [EW-1:0]     enable_next;
  reg  [31:0]       prdata_next;
  wire [EW-1:0]     evt_level;
  wire [EW-1:0]     evt_pulse;
  wire [EW-1:0]     evt_flags;
  wire [EW-1:0]     evt_clr;
  wire [9:0]        index;
  wire              mapped;
  wire              setup_phase;
  wire              access_phase;
  wire              wr_access;
  wire              rd_access;
  wire              link_qualified;
  wire              event_irq;

  // ---------------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------------
  assign index        = paddr[11:2];
  assign mapped       = (paddr[1:0] == 2'h0)
                      && ((index == `IDX_PHY_RESOLVED_STATUS)
                       || (index == `IDX_INTERRUPT_CONTROL)
                       || (index == `IDX_INTERRUPT_EVENT_STATUS));
  assign setup_phase  = psel & ~penable;
  assign access_phase = psel & penable;
  assign wr_access    = access_phase & pwrite & mapped;
  assign rd_access    = access_phase & ~pwrite & mapped;

  // Read data is captured in the setup cycle, so no wait state is needed
  assign pready  = 1'b1;
  assign pslverr = access_phase & ~mapped;

  // ---------------------------------------------------------------------
  // Resolved status
  // ---------------------------------------------------------------------
  // Speed and duplex are meaningful only with a link and finished or
  // disabled auto-negotiation; outside that they hold their last value.
  assign link_qualified = link_up & (~an_enable | an_complete);          // [RULE_02]

  always @* begin
    status_next = status_reg;
    status_next[`STS_LINK_BIT] = link_up;                                // [RULE_04]
    if (link_qualified) begin
      status_next[`STS_SPEED10_BIT] = speed_is_10;                       // [RULE_03] [RULE_02]
      status_next[`STS_DUPLEX_BIT]  = full_duplex;                       // [RULE_01] [RULE_02]
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= `STS_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  // ---------------------------------------------------------------------
  // Event detection
  // ---------------------------------------------------------------------
  // Speed and duplex changes follow the reported values, not the raw inputs
  assign evt_level[`EVT_RX_ERR_HALF]        = rx_error_half_full;        // [RULE_09]
  assign evt_level[`EVT_FALSE_CARRIER_HALF] = false_carrier_half_full;   // [RULE_09]
  assign evt_level[`EVT_AN_COMPLETE]        = an_complete;               // [RULE_09]
  assign evt_level[`EVT_DUPLEX_CHANGE]      = status_reg[`STS_DUPLEX_BIT];
  assign evt_level[`EVT_SPEED_CHANGE]       = status_reg[`STS_SPEED10_BIT];
  assign evt_level[`EVT_LINK_CHANGE]        = status_reg[`STS_LINK_BIT];
  assign evt_level[`EVT_ENERGY_CHANGE]      = energy_detect;             // [RULE_09]

  event_edge_detect #(
    .W         (EW),
    .RISE_ONLY (RISE_MASK)
  ) u_edges (
    .clk   (pclk),
    .rst_n (presetn),
    .level (evt_level),
    .pulse (evt_pulse)
  );

  // Reading the event status clears exactly the bits returned by that read;
  // a write of one to a status bit clears it as well. A new event wins.
  assign evt_clr = rd_access && (index == `IDX_INTERRUPT_EVENT_STATUS)
                 ? prdata[`EVT_STATUS_LSB +: EW]                          // [RULE_14]
                 : (wr_access && (index == `IDX_INTERRUPT_EVENT_STATUS)
                    ? pwdata[`EVT_STATUS_LSB +: EW] : {EW{1'b0}});

  // Flags are set from raw events, ignoring every enable
  sticky_flags #(
    .W (EW)
  ) u_flags (
    .clk   (pclk),
    .rst_n (presetn),
    .set   (evt_pulse),                                                  // [RULE_11] [RULE_12]
    .clr   (evt_clr),
    .flags (evt_flags)
  );

  // ---------------------------------------------------------------------
  // Writable registers
  // ---------------------------------------------------------------------
  always @* begin
    control_next = control_reg;
    enable_next  = enable_reg;
    if (wr_access && (index == `IDX_INTERRUPT_CONTROL)) begin
      control_next = pwdata[2:0];                                        // [RULE_05]
    end
    if (wr_access && (index == `IDX_INTERRUPT_EVENT_STATUS)) begin
      enable_next = pwdata[`EVT_ENABLE_LSB +: EW];                       // [RULE_10]
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_reg <= `CTL_RESET;
      enable_reg  <= `EVT_ENABLE_RESET;
    end else begin
      control_reg <= control_next;
      enable_reg  <= enable_next;
    end
  end

  // ---------------------------------------------------------------------
  // Read data, captured during the setup cycle
  // ---------------------------------------------------------------------
  always @* begin
    prdata_next = prdata;
    if (setup_phase) begin
      prdata_next = 32'h0000_0000;
      if (!pwrite) begin
        case (index)
          `IDX_PHY_RESOLVED_STATUS: begin
            prdata_next[2:0] = status_reg;                               // [RULE_01] [RULE_03] [RULE_04]
          end
          `IDX_INTERRUPT_CONTROL: begin
            prdata_next[2:0] = control_reg;                              // [RULE_05]
          end
          `IDX_INTERRUPT_EVENT_STATUS: begin
            prdata_next[`EVT_STATUS_LSB +: EW] = evt_flags;
            prdata_next[`EVT_ENABLE_LSB +: EW] = enable_reg;
          end
          default: begin
            prdata_next = 32'h0000_0000;
          end
        endcase
        if (paddr[1:0] != 2'h0) begin
          prdata_next = 32'h0000_0000;
        end
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= prdata_next;
    end
  end

  // ---------------------------------------------------------------------
  // Interrupt and shared pin
  // ---------------------------------------------------------------------
  assign event_irq = control_reg[`CTL_GLOBAL_EN_BIT]                     // [RULE_07] [RULE_13]
                   & (|(evt_flags & enable_reg));                        // [RULE_10] [RULE_13]

  // Level output: holds while a pending enabled event or the test bit stays
  assign irq = event_irq | control_reg[`CTL_TEST_INT_BIT];               // [RULE_06] [RULE_15]

  // The pin is an active-low interrupt output, or an active-low power-down input
  assign powerdown_irq_shared_pin_oe  = control_reg[`CTL_INT_OE_BIT];    // [RULE_08]
  assign powerdown_irq_shared_pin_out = ~irq;
  assign power_down_req = ~control_reg[`CTL_INT_OE_BIT]                  // [RULE_08]
                        & ~powerdown_irq_shared_pin_in;

endmodule

// ### bench/phy_status_interrupt_ctrl_sva.sv
/*
  Port checker of the PHY status and interrupt block.
  Assumes APB byte addresses 0x40, 0x44, 0x48 and is bound to the top module.
*/
`timescale 1ns/1ps
module phy_irq_sva #(
  parameter ADDR_W = 12
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              link_up,
  input wire logic              powerdown_irq_shared_pin_in,
  input wire logic              powerdown_irq_shared_pin_out,
  input wire logic              powerdown_irq_shared_pin_oe,
  input wire logic              power_down_req,
  input wire logic              irq
);
  logic [2:0] up_cnt;
  // Cycles since reset release, so history from reset is never compared
  always @(posedge pclk or negedge presetn)
    if (!presetn) up_cnt <= 3'h0;
    else if (up_cnt != 3'h7) up_cnt <= up_cnt + 3'h1;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wr_ctl; psel && penable && pwrite && paddr == 12'h044; endsequence
  sequence s_rd_ctl; psel && penable && !pwrite && paddr == 12'h044; endsequence
  sequence s_rd_sts; psel && penable && !pwrite && paddr == 12'h040; endsequence
  sequence s_link_calm; $stable(link_up) [*3] ##0 up_cnt == 3'h7; endsequence
  AST_PIN_OUT: assert property (powerdown_irq_shared_pin_oe |->
    powerdown_irq_shared_pin_out == !irq) else $error("pin not inverse of irq");
  AST_PWR_DOWN: assert property (power_down_req ==
    (!powerdown_irq_shared_pin_oe && !powerdown_irq_shared_pin_in)) else $error("bad pd req");
  AST_OE_WRITE: assert property (s_wr_ctl |=>
    powerdown_irq_shared_pin_oe == $past(pwdata[0])) else $error("oe not written");
  AST_OE_HOLD: assert property (!(psel && penable && pwrite) |=>
    $stable(powerdown_irq_shared_pin_oe)) else $error("oe moved without write");
  AST_CTL_RSV: assert property (s_rd_ctl |-> prdata[31:3] == 29'h0)
    else $error("reserved control bits nonzero");
  AST_TEST_INT: assert property (s_rd_ctl ##0 (prdata[2] && !$past(penable)) |-> irq)
    else $error("test interrupt without irq");
  AST_IRQ_HOLD: assert property (irq && !(psel && penable) |=> irq)
    else $error("irq dropped without access");
  AST_IRQ_FALL: assert property ($fell(irq) |-> $past(psel && penable &&
    (paddr == 12'h044 || paddr == 12'h048))) else $error("irq fell without access");
  AST_LINK_MIRROR: assert property (s_link_calm ##0 s_rd_sts |->
    prdata[0] == link_up) else $error("link bit wrong");
endmodule
bind phy_status_interrupt_ctrl phy_irq_sva #(.ADDR_W(ADDR_W)) u_sva (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .link_up,
  .powerdown_irq_shared_pin_in, .powerdown_irq_shared_pin_out,
  .powerdown_irq_shared_pin_oe, .power_down_req, .irq
);

// ### bench/apb_host_model.sv
/*
  Host processor model: APB master issuing one transfer per task call.
  Assumes a slave that raises pready within the bench timeout.
*/
`timescale 1ns/1ps
module apb_host_model (
  input  wire logic        pclk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
  end
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
            output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ### bench/phy_status_interrupt_ctrl_tb_top.sv
/*
  Testbench of the PHY status and interrupt block.
  Assumes the host model, the checker and the design files are compiled first.
*/
`timescale 1ns/1ps
module phy_status_interrupt_ctrl_tb_top;
  logic        pclk, presetn, an_enable, pin_in, psel, penable, pwrite, err;
  logic        pready, pslverr, pin_out, pin_oe, power_down_req, irq;
  logic [6:0]  src;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, en;
  int          fail_count, total_checks, i;
  apb_host_model host (.pclk, .prdata, .pready, .pslverr, .psel, .penable, .pwrite,
    .paddr, .pwdata);
  phy_status_interrupt_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .an_enable, .power_down_req, .irq,
    .rx_error_half_full(src[0]), .false_carrier_half_full(src[1]), .an_complete(src[2]),
    .full_duplex(src[3]), .speed_is_10(src[4]), .link_up(src[5]), .energy_detect(src[6]),
    .powerdown_irq_shared_pin_in(pin_in), .powerdown_irq_shared_pin_out(pin_out),
    .powerdown_irq_shared_pin_oe(pin_oe));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task summarize;
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rd, err);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e, input string n);
    host.xfer(1'b0, a, 32'h0, rd, err);
    chk(n, e, rd);
    #1;
  endtask
  // Sources 0..2 count on a rising edge only, the others on any change
  task fire(input int k);
    @(posedge pclk);
    if (k < 3) begin
      src[k] <= 1'b0;
      repeat (3) @(posedge pclk);
    end
    src[k] <= ~src[k];
    repeat (5) @(posedge pclk);
    #1;
  endtask
  initial begin
    #100000;
    fail_count++;
    summarize();
  end
  initial begin
    presetn = 1'b0;
    src = 7'h0;
    an_enable = 1'b0;
    pin_in = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk("pd_req", 32'h1, power_down_req);
    @(posedge pclk);
    pin_in <= 1'b1;
    #1;
    chk("pd_req", 32'h0, power_down_req);
    rdc(12'h044, 32'h0, "control");
    rdc(12'h048, 32'h0, "events");
    rdc(12'h040, 32'h0, "status");
    @(posedge pclk);
    src[5:3] <= 3'b111;
    repeat (4) @(posedge pclk);
    rdc(12'h040, 32'h7, "status");
    rdc(12'h040, 32'h7, "status");
    @(posedge pclk);
    an_enable <= 1'b1;
    src[4] <= 1'b0;
    repeat (4) @(posedge pclk);
    rdc(12'h040, 32'h7, "status");
    @(posedge pclk);
    src[2] <= 1'b1;
    repeat (4) @(posedge pclk);
    rdc(12'h040, 32'h5, "status");
    rdc(12'h048, 32'h3c00, "events");
    rdc(12'h048, 32'h0, "events");
    rdc(12'h04c, 32'h0, "unmapped");
    chk("slverr", 32'h1, err);
    wr(12'h044, 32'hffffffff);
    rdc(12'h044, 32'h7, "control");
    chk("irq", 32'h1, irq);
    wr(12'h044, 32'h1);
    #1;
    chk("pin_oe", 32'h1, pin_oe);
    chk("pin_out", 32'h1, pin_out);
    wr(12'h048, 32'h7f);
    fire(6);
    chk("irq", 32'h0, irq);
    rdc(12'h048, 32'h407f, "events");
    wr(12'h044, 32'h3);
    for (i = 0; i < 14; i++) begin
      en = (i % 2) ? (32'h1 << (i / 2)) : (32'h7f ^ (32'h1 << (i / 2)));
      wr(12'h048, en);
      fire(i / 2);
      chk("irq", i % 2, irq);
      rdc(12'h048, en | (32'h100 << (i / 2)), "events");
      chk("irq", 32'h0, irq);
    end
    summarize();
  end
endmodule
